//--- inc/npe_cfg.svh
// Offsets, field positions, reset values and timing counts for the nvm control block
`ifndef NPE_CFG_SVH
`define NPE_CFG_SVH

// Register word indexes; byte address is four times the index
`define NPE_IDX_NV_PROG 16'h103B
`define NPE_IDX_EPROM_PROG 16'h1036
`define NPE_IDX_BLOCK_PROT 16'h1035
`define NPE_IDX_PUMP_OPT 16'h1039
`define NPE_IDX_CONFIG 16'h103F
`define NPE_IDX_EE512_BASE 16'hB600
`define NPE_EE2K_LOW 12'h800
`define NPE_IDX_EPROM_LO 16'hD000

// Shared programming register fields
`define NPE_NV_ODD 7
`define NPE_NV_EVEN 6
`define NPE_NV_BYTE 4
`define NPE_NV_ROW 3
`define NPE_NV_ERASE 2
`define NPE_NV_EEPROM_LATCH_CTL 1
`define NPE_NV_EEPROM_HV_ENABLE 0

// EPROM programming register fields
`define NPE_EP_EPROM_LATCH_CTL 5
`define NPE_EP_EXTRA_COLUMN_SEL 4
`define NPE_EP_EXTRA_ROW_SEL 3
`define NPE_EP_T_HI 2
`define NPE_EP_T_LO 1
`define NPE_EP_PGM 0

// Block protect, pump option and config fields
`define NPE_BP_SETUP_WRITE_PROTECT 4
`define NPE_PO_PUMP_CLK_SEL 6
`define NPE_CFG_EEPROM_VISIBLE_EN 0
`define NPE_CFG_EE_HI 7
`define NPE_CFG_EE_LO 4

// Reset values
`define NPE_NV_RESET 8'h00
`define NPE_EP_RESET 8'h00
`define NPE_BP_RESET 5'h1F
`define NPE_PO_RESET 1'b0

// Timing
`define NPE_CLK_PERIOD_NS 4
`define NPE_PROT_WINDOW_CYC 7'd64
`define NPE_EE_PROG_TIME_NS 10000000
`define NPE_EE_PROG_CYC ((`NPE_EE_PROG_TIME_NS + `NPE_CLK_PERIOD_NS - 1) / `NPE_CLK_PERIOD_NS)

`endif

//--- inc/npe_pkg.sv
// Types shared by the nvm program and erase control block
`default_nettype none
package npe_pkg;
	// What a pending EEPROM-cell operation is aimed at
	typedef enum logic [1:0] {
		NPE_TGT_NONE,
		NPE_TGT_ARRAY,
		NPE_TGT_CONFIG
	} npe_target_e;
endpackage : npe_pkg
`default_nettype wire

//--- rtl/npe_nvm_ctrl.sv
// APB-controlled EPROM and EEPROM program and erase sequencing
//
// Operation
// - EPROM latch on: writes latch, reads blocked
// - EPROM latch frozen while EPROM voltage on
// - EPROM voltage writable only with latch set
// - Extra columns: address 13:5, special only
// - Extra rows: address 7:0, special only
// - Stress select two bits, special only
// - Unimplemented register bits read zero
// - Erased reads one; program clears bits
// - Control always accessible; sequences still enforced
// - EEPROM latch off: array reads as ROM
// - Pump clock select: E or RC
// - Voltage needs latch, target write, then both
// - Setting latch and voltage together sets neither
// - Protect bits reset set; clear in window
// - Writing ones to protect always accepted
// - Special modes lift the reset window
// - Array visible only with visible enable
// - Config protect blocks config program, erase
// - Small part: four uneven protected ranges
// - Large part: four quarters, base selectable
// - Byte, row or bulk erase size
// - Erase bit selects erase over program
// - Both latch bits never set together
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "npe_cfg.svh"
`default_nettype none

module npe_nvm_ctrl #(
	parameter int EE_BYTES = 512,
	parameter int unsigned EE_PROG_CYCLES = `NPE_EE_PROG_CYC,
	parameter logic [7:0] CONFIG_RESET = 8'h0F
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [17:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic special_mode_i,
	input wire logic [7:0] eprom_rdata_i,
	output logic [13:0] eprom_addr_o,
	output logic [7:0] eprom_wdata_o,
	output logic eprom_latch_o,
	output logic eprom_hv_o,
	output logic eprom_extra_col_o,
	output logic eprom_extra_row_o,
	output logic [1:0] eprom_stress_o,
	output logic eeprom_hv_o,
	output logic pump_clk_sel_o,
	output logic [7:0] config_o
);
	import npe_pkg::*;

	localparam int AW = $clog2(EE_BYTES);
	localparam logic [15:0] EE_SIZE16 = 16'(EE_BYTES);
	localparam logic [31:0] FIRE_AT = 32'(EE_PROG_CYCLES - 1);

	// Only the two documented array sizes have a protect map
	generate
		if (EE_BYTES != 512 && EE_BYTES != 2048)
			$error("EE_BYTES must be 512 or 2048");
		if (EE_PROG_CYCLES < 1)
			$error("EE_PROG_CYCLES must be at least 1");
	endgenerate

	// Register state
	logic [7:0] nv_reg;
	logic eprom_latch_ctl_reg;
	logic pgm_reg;
	logic extra_column_sel_reg;
	logic extra_row_sel_reg;
	logic [1:0] stress_reg;
	logic [4:0] bp_reg;
	logic pump_reg;
	logic [7:0] cfg_reg;
	logic [7:0] ee_mem [EE_BYTES];
	logic [13:0] ep_addr_reg;
	logic [7:0] ep_data_reg;
	npe_target_e tgt_reg;
	logic [AW-1:0] op_addr_reg;
	logic [7:0] op_data_reg;
	logic [31:0] hv_cnt_reg;
	logic [6:0] win_cnt_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// Protect block of an array offset
	function automatic logic [1:0] blk_of(input logic [10:0] off);
		logic [1:0] b;
		b = off[10:9];
		if (EE_BYTES == 512)
		begin
			if (off < 11'h020)
				b = 2'h0;
			else if (off < 11'h060)
				b = 2'h1;
			else if (off < 11'h0E0)
				b = 2'h2;
			else
				b = 2'h3;
		end
		return b;
	endfunction : blk_of

	// EPROM address as the cells see it in extra column or row access
	function automatic logic [13:0] ep_map(input logic [13:0] a);
		logic [13:0] m;
		m = a;
		if (extra_column_sel_reg)
			m = {a[13:5], 5'h00};
		else if (extra_row_sel_reg)
			m = {6'h00, a[7:0]};
		return m;
	endfunction : ep_map

	// Handy views of the shared programming and config registers
	wire eeprom_latch_ctl = nv_reg[`NPE_NV_EEPROM_LATCH_CTL];
	wire eeprom_hv_enable = nv_reg[`NPE_NV_EEPROM_HV_ENABLE];
	wire eeprom_visible_en = cfg_reg[`NPE_CFG_EEPROM_VISIBLE_EN];
	wire [3:0] ee_sel = cfg_reg[`NPE_CFG_EE_HI:`NPE_CFG_EE_LO];

	// Address decode
	// EEPROM window is tested first, so it wins where it overlaps EPROM
	wire [15:0] idx = paddr_i[17:2];
	wire aligned = (paddr_i[1:0] == 2'h0);
	wire [15:0] ee_base = (EE_BYTES == 512) ? `NPE_IDX_EE512_BASE : {ee_sel, `NPE_EE2K_LOW};
	wire [15:0] ee_diff = idx - ee_base;
	wire hit_ee = eeprom_visible_en && (idx >= ee_base) && (ee_diff < EE_SIZE16);
	wire [AW-1:0] ee_off = ee_diff[AW-1:0];
	wire [15:0] ep_diff = idx - `NPE_IDX_EPROM_LO;
	wire hit_eprom = (idx >= `NPE_IDX_EPROM_LO) && !hit_ee;
	wire hit_nv = (idx == `NPE_IDX_NV_PROG);
	wire hit_ep = (idx == `NPE_IDX_EPROM_PROG);
	wire hit_bp = (idx == `NPE_IDX_BLOCK_PROT);
	wire hit_po = (idx == `NPE_IDX_PUMP_OPT);
	wire hit_cfg = (idx == `NPE_IDX_CONFIG);
	wire mapped = aligned && (hit_nv || hit_ep || hit_bp || hit_po || hit_cfg || hit_ee || hit_eprom);

	// Bus phases: two access cycles so read data leaves a flop
	wire setup = psel_i && !penable_i;
	wire acc_first = psel_i && penable_i && !pready_reg;
	wire done = psel_i && penable_i && pready_reg;
	wire wr = done && pwrite_i && mapped;
	wire [7:0] w = pwdata_i[7:0];

	// Register read views
	wire [7:0] ep_view = {2'h0, eprom_latch_ctl_reg, extra_column_sel_reg && special_mode_i, extra_row_sel_reg && special_mode_i,
		special_mode_i ? stress_reg : 2'h0, pgm_reg};
	wire [7:0] ee_rd = eeprom_latch_ctl ? 8'h00 : ee_mem[ee_off];
	wire [7:0] eprom_rd = eprom_latch_ctl_reg ? 8'h00 : eprom_rdata_i;

	// Read data mux
	wire [7:0] rd_byte = !mapped ? 8'h00 :
		hit_nv ? nv_reg :
		hit_ep ? ep_view :
		hit_bp ? {3'h0, bp_reg} :
		hit_po ? {1'b0, pump_reg, 6'h00} :
		hit_cfg ? cfg_reg :
		hit_ee ? ee_rd : eprom_rd;

	// Shared register write decisions
	wire both_try = w[`NPE_NV_EEPROM_LATCH_CTL] && w[`NPE_NV_EEPROM_HV_ENABLE] && !eeprom_latch_ctl && !eeprom_hv_enable;
	wire eeprom_latch_ctl_new = w[`NPE_NV_EEPROM_LATCH_CTL] && !eprom_latch_ctl_reg && !both_try;
	wire eeprom_hv_enable_new = w[`NPE_NV_EEPROM_HV_ENABLE] && eeprom_latch_ctl && eeprom_latch_ctl_new && (tgt_reg != NPE_TGT_NONE);

	// EPROM register write decisions
	wire eprom_latch_ctl_new = pgm_reg ? eprom_latch_ctl_reg : (w[`NPE_EP_EPROM_LATCH_CTL] && !eeprom_latch_ctl);
	wire pgm_new = eprom_latch_ctl_reg ? w[`NPE_EP_PGM] : pgm_reg;

	// Protect window and the value a protect write leaves
	wire win_open = (win_cnt_reg < `NPE_PROT_WINDOW_CYC);
	wire clr_ok = special_mode_i || win_open;
	wire [4:0] bp_new = clr_ok ? w[4:0] : (bp_reg | w[4:0]);

	// Operation fires once after the voltage has stood long enough
	wire op_fire = eeprom_hv_enable && (hv_cnt_reg == FIRE_AT);
	wire erase_mode = nv_reg[`NPE_NV_ERASE];
	wire op_byte = nv_reg[`NPE_NV_BYTE];
	wire op_row = nv_reg[`NPE_NV_ROW];

	// One erase select per cell byte; size, protect and erase bit all agree
	wire [EE_BYTES-1:0] erase_hit;
	generate
		for (genvar gi = 0; gi < EE_BYTES; gi = gi + 1)
		begin : g_erase
			wire logic [AW-1:0] own_addr = AW'(gi);
			// Protected blocks keep their bytes through any erase size
			wire logic blk_free = !bp_reg[blk_of(11'(gi))];
			wire logic in_row = (own_addr[AW-1:4] == op_addr_reg[AW-1:4]);
			wire logic size_hit = op_byte ? (own_addr == op_addr_reg) :
				(op_row ? in_row : 1'b1);
			assign erase_hit[gi] = erase_mode && blk_free && size_hit;
		end
	endgenerate

	// Bus answer flops
	// Registered read data costs a wait state but keeps outputs on flops
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else if (acc_first)
		begin
			prdata_reg <= {24'h00_0000, pwrite_i ? 8'h00 : rd_byte};
			pready_reg <= 1'b1;
			pslverr_reg <= !mapped; // Unmapped or unaligned
		end
		else
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	// Shared programming register; stray writes cannot raise voltage
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			nv_reg <= `NPE_NV_RESET;
		else if (wr && hit_nv)
		begin
			nv_reg <= {w[7:6], 1'b0, w[4:2], eeprom_latch_ctl_new, eeprom_hv_enable_new};
		end
	end

	// Armed target, captured by the write between the two control writes
	// Dropping the latch disarms, so a stale target cannot reach a later voltage-on
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			tgt_reg <= NPE_TGT_NONE;
			op_addr_reg <= '0;
			op_data_reg <= 8'h00;
		end
		else if (!eeprom_latch_ctl)
			tgt_reg <= NPE_TGT_NONE;
		else if (wr && !eeprom_hv_enable && (hit_ee || hit_cfg))
		begin
			tgt_reg <= hit_ee ? NPE_TGT_ARRAY : NPE_TGT_CONFIG;
			op_addr_reg <= ee_off;
			op_data_reg <= w;
		end
	end

	// Voltage-on timer; restarts whenever the voltage drops
	// Counter parks past the firing count so each voltage-on applies once
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || !eeprom_hv_enable)
			hv_cnt_reg <= 32'h0000_0000;
		else if (hv_cnt_reg <= FIRE_AT)
			hv_cnt_reg <= hv_cnt_reg + 32'h0000_0001;
	end

	// EPROM programming register and its latches
	// Read address follows setup so array data settles within the first access cycle
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			eprom_latch_ctl_reg <= 1'b0;
			pgm_reg <= 1'b0;
			extra_column_sel_reg <= 1'b0;
			extra_row_sel_reg <= 1'b0;
			stress_reg <= 2'h0;
			ep_addr_reg <= 14'h0000;
			ep_data_reg <= 8'h00;
		end
		else
		begin
			if (wr && hit_ep)
			begin
				eprom_latch_ctl_reg <= eprom_latch_ctl_new;
				pgm_reg <= pgm_new;
				extra_column_sel_reg <= special_mode_i && w[`NPE_EP_EXTRA_COLUMN_SEL];
				extra_row_sel_reg <= special_mode_i && w[`NPE_EP_EXTRA_ROW_SEL];
				stress_reg <= special_mode_i ? w[`NPE_EP_T_HI:`NPE_EP_T_LO] : 2'h0;
			end
			else if (!special_mode_i)
			begin
				// Test selects must never act in normal modes
				extra_column_sel_reg <= 1'b0;
				extra_row_sel_reg <= 1'b0;
				stress_reg <= 2'h0;
			end
			if (wr && hit_eprom && eprom_latch_ctl_reg)
			begin
				ep_addr_reg <= ep_map(ep_diff[13:0]);
				ep_data_reg <= w;
			end
			else if (setup && !eprom_latch_ctl_reg)
				ep_addr_reg <= ep_map(ep_diff[13:0]);
		end
	end

	// Block protect and its reset window
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			bp_reg <= `NPE_BP_RESET;
			win_cnt_reg <= 7'h00;
		end
		else
		begin
			if (win_open)
				win_cnt_reg <= win_cnt_reg + 7'h01;
			if (wr && hit_bp)
				bp_reg <= bp_new;
		end
	end

	// Pump clock option
	// Only the select is kept; the pump and its oscillator sit outside
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			pump_reg <= `NPE_PO_RESET;
		else if (wr && hit_po)
			pump_reg <= w[`NPE_PO_PUMP_CLK_SEL];
	end

	// Config cells; only the program and erase sequence changes them
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			cfg_reg <= CONFIG_RESET;
		else if (op_fire && tgt_reg == NPE_TGT_CONFIG && !bp_reg[`NPE_BP_SETUP_WRITE_PROTECT])
			cfg_reg <= erase_mode ? 8'hFF : (cfg_reg & op_data_reg);
	end

	// Array cells; no reset, contents are nonvolatile
	// Limitation: contents start unknown, so software erases before first use
	always_ff @(posedge core_clk_i)
	begin
		if (op_fire && tgt_reg == NPE_TGT_ARRAY)
		begin
			for (int i = 0; i < EE_BYTES; i++)
			begin
				if (erase_hit[i])
					ee_mem[i] <= 8'hFF;
			end
			if (!erase_mode && !bp_reg[blk_of(11'(op_addr_reg))])
				ee_mem[op_addr_reg] <= ee_mem[op_addr_reg] & op_data_reg;
		end
	end

	// Outputs straight from flops
	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign eprom_addr_o = ep_addr_reg;
	assign eprom_wdata_o = ep_data_reg;
	assign eprom_latch_o = eprom_latch_ctl_reg;
	assign eprom_hv_o = pgm_reg;
	assign eprom_extra_col_o = extra_column_sel_reg;
	assign eprom_extra_row_o = extra_row_sel_reg;
	assign eprom_stress_o = stress_reg;
	assign eeprom_hv_o = nv_reg[`NPE_NV_EEPROM_HV_ENABLE];
	assign pump_clk_sel_o = pump_reg;
	assign config_o = cfg_reg;
endmodule : npe_nvm_ctrl

`default_nettype wire

//--- verification/npe_nvm_ctrl_sva.sv
// Port assertions for the nvm program and erase control block
`timescale 1ns/1ps
`default_nettype none
module npe_nvm_ctrl_sva (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic special_mode_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic eprom_latch_o,
	input wire logic eprom_hv_o,
	input wire logic eprom_extra_col_o,
	input wire logic eprom_extra_row_o,
	input wire logic [1:0] eprom_stress_o,
	input wire logic eeprom_hv_o,
	input wire logic pump_clk_sel_o
);
	wire logic wr_done;
	// Completed write; control state may only move on one of these
	assign wr_done = psel_i & penable_i & pwrite_i & pready_o;
	default clocking dc @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	ready_time_a: assert property (psel_i && $rose(penable_i) |=> pready_o)
		else $error("no answer in second access cycle");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	err_read_a: assert property (pslverr_o |-> pready_o && (pwrite_i || prdata_o == 32'h0000_0000))
		else $error("refused access misbehaved");
	hv_latch_a: assert property ($rose(eprom_hv_o)
		|-> $past(wr_done) && $past(eprom_latch_o))
		else $error("eprom voltage on without latch");
	latch_frozen_a: assert property (eprom_hv_o |=> $stable(eprom_latch_o))
		else $error("eprom latch moved under voltage");
	normal_zero_a: assert property (!special_mode_i && !$past(special_mode_i)
		|-> !eprom_extra_col_o && !eprom_extra_row_o && eprom_stress_o == 2'b00)
		else $error("test selects active in normal mode");
	pump_write_a: assert property ($changed(pump_clk_sel_o) |-> $past(wr_done))
		else $error("pump clock select moved without write");
	ee_volt_a: assert property ($rose(eeprom_hv_o) |-> $past(wr_done) && !eprom_latch_o)
		else $error("eeprom voltage rose out of sequence");
endmodule : npe_nvm_ctrl_sva
bind npe_nvm_ctrl npe_nvm_ctrl_sva npe_nvm_ctrl_sva_i (.core_clk_i, .rst_n_i, .psel_i, .penable_i,
	.pwrite_i, .special_mode_i, .prdata_o, .pready_o, .pslverr_o, .eprom_latch_o, .eprom_hv_o,
	.eprom_extra_col_o, .eprom_extra_row_o, .eprom_stress_o, .eeprom_hv_o, .pump_clk_sel_o);
`default_nettype wire

//--- verification/npe_nvm_ctrl_tb.sv
// Self-checking bench for the nvm program and erase control block
`timescale 1ns/1ps
`include "npe_cfg.svh"
`default_nettype none
module npe_nvm_ctrl_tb;
	localparam int PROG = 8;
	localparam logic [15:0] NV = `NPE_IDX_NV_PROG;
	localparam logic [15:0] EP = `NPE_IDX_EPROM_PROG;
	localparam logic [15:0] BP = `NPE_IDX_BLOCK_PROT;
	localparam logic [15:0] EE = `NPE_IDX_EE512_BASE;
	localparam logic [15:0] ER = `NPE_IDX_EPROM_LO;
	localparam logic [15:0] CF = `NPE_IDX_CONFIG;
	localparam logic [15:0] PO = `NPE_IDX_PUMP_OPT;
	logic core_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, special_mode_i, pready_o, pslverr_o;
	logic eprom_latch_o, eprom_hv_o, eprom_extra_col_o, eprom_extra_row_o, eeprom_hv_o;
	logic pump_clk_sel_o, last_err;
	logic [17:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic [13:0] eprom_addr_o;
	logic [7:0] eprom_rdata_i, eprom_wdata_o, config_o;
	logic [1:0] eprom_stress_o;
	int mismatches = 0;
	int check_count = 0;
	// Short program time keeps each cell operation to a few cycles
	npe_nvm_ctrl #(.EE_PROG_CYCLES(PROG)) npe_nvm_ctrl_i (.core_clk_i, .rst_n_i, .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.special_mode_i, .eprom_rdata_i, .eprom_addr_o, .eprom_wdata_o, .eprom_latch_o,
		.eprom_hv_o, .eprom_extra_col_o, .eprom_extra_row_o, .eprom_stress_o, .eeprom_hv_o,
		.pump_clk_sel_o, .config_o);
	// 250 MHz clock
	always #2 core_clk_i = ~core_clk_i;
	task automatic print_verdict();
		if (mismatches == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Request held until ready is sampled; answer taken at that edge
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d,
		output logic [31:0] r);
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= 32'(d);
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		// No fixed wait; only the watchdog ends a hung transfer
		do
		begin
			@(posedge core_clk_i);
		end
		while (pready_o !== 1'b1);
		r = prdata_o;
		last_err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	// Half-cycle pause lets the write edge land before outputs are looked at
	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] r;
		apb(1'b1, idx, d, r);
		@(negedge core_clk_i);
	endtask : wr
	task automatic rc(input string nm, input logic [15:0] idx, input logic [7:0] e);
		logic [31:0] r;
		apb(1'b0, idx, 8'h00, r);
		chk(nm, r, 32'(e));
	endtask : rc
	task automatic ee_op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
		wr(NV, c);
		wr(a, d);
		wr(NV, c | 8'h01);
		chk("ee hv", 32'(eeprom_hv_o), 32'h1);
		repeat (PROG + 2) @(posedge core_clk_i);
		wr(NV, 8'h00);
	endtask : ee_op
	task automatic t_protect();
		rc("bp reset", BP, 8'h1F);
		wr(BP, 8'hE0);
		rc("bp early clear", BP, 8'h00);
		wr(BP, 8'h05);
		rc("bp set", BP, 8'h05);
		rc("nv reset", NV, 8'h00);
		rc("ep reset", EP, 8'h00);
		rc("unmapped", 16'h0000, 8'h00);
		chk("unmapped err", 32'(last_err), 32'h1);
		repeat (64) @(posedge core_clk_i);
		wr(BP, 8'h00);
		rc("bp late clear", BP, 8'h05);
		@(posedge core_clk_i);
		special_mode_i <= 1'b1;
		wr(BP, 8'h00);
		rc("bp special", BP, 8'h00);
	endtask : t_protect
	task automatic t_special();
		for (int i = 0; i < 4; i++)
		begin
			wr(EP, 8'h18 | 8'(i << 1));
			rc("test ctl", EP, 8'h18 | 8'(i << 1));
			chk("stress", 32'(eprom_stress_o), 32'(i));
		end
		chk("extra", 32'({eprom_extra_col_o, eprom_extra_row_o}), 32'h3);
		wr(EP, 8'h30);
		wr(ER + 16'h0125, 8'h77);
		chk("col addr", 32'(eprom_addr_o), 32'h120);
		wr(EP, 8'h28);
		wr(ER + 16'h0125, 8'h66);
		chk("row addr", 32'(eprom_addr_o), 32'h25);
		wr(EP, 8'h00);
		@(posedge core_clk_i);
		special_mode_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rc("normal ctl", EP, 8'h00);
	endtask : t_special
	task automatic t_eprom();
		wr(EP, 8'h01);
		rc("hv no latch", EP, 8'h00);
		wr(EP, 8'h3E);
		rc("latch only", EP, 8'h20);
		chk("latch out", 32'(eprom_latch_o), 32'h1);
		rc("eprom blocked", ER + 16'h0005, 8'h00);
		wr(ER + 16'h0005, 8'h5A);
		chk("lat addr", 32'(eprom_addr_o), 32'h5);
		chk("lat data", 32'(eprom_wdata_o), 32'h5A);
		wr(EP, 8'h21);
		chk("hv on", 32'(eprom_hv_o), 32'h1);
		wr(EP, 8'h00);
		rc("latch held", EP, 8'h20);
		wr(EP, 8'h00);
		rc("eprom read", ER + 16'h0005, 8'h3C);
	endtask : t_eprom
	task automatic t_eeprom();
		ee_op(8'h06, EE + 16'h0100, 8'h00);
		rc("bulk", EE + 16'h01FF, 8'hFF);
		ee_op(8'h02, EE, 8'hA5);
		rc("program", EE, 8'hA5);
		ee_op(8'h02, EE, 8'hF0);
		rc("program and", EE, 8'hA0);
		ee_op(8'h02, EE + 16'h0011, 8'h00);
		ee_op(8'h0E, EE + 16'h0013, 8'h00);
		rc("row", EE + 16'h0011, 8'hFF);
		rc("row edge", EE, 8'hA0);
		ee_op(8'h02, CF, 8'hFE);
		chk("cfg prog", 32'(config_o), 32'h0E);
		rc("hidden", EE, 8'h00);
		chk("hidden err", 32'(last_err), 32'h1);
		ee_op(8'h16, CF, 8'h00);
		chk("cfg erase", 32'(config_o), 32'hFF);
		wr(BP, 8'h11);
		ee_op(8'h02, CF, 8'h00);
		chk("cfg locked", 32'(config_o), 32'hFF);
		ee_op(8'h16, EE, 8'h00);
		rc("protected", EE, 8'hA0);
		wr(NV, 8'h03);
		rc("both bits", NV, 8'h00);
		wr(NV, 8'h02);
		rc("latched read", EE, 8'h00);
		wr(NV, 8'h03);
		chk("no target", 32'(eeprom_hv_o), 32'h0);
		wr(NV, 8'h00);
		wr(EP, 8'h20);
		wr(NV, 8'h02);
		rc("exclusive", NV, 8'h00);
		wr(EP, 8'h00);
		wr(PO, 8'h40);
		chk("pump", 32'(pump_clk_sel_o), 32'h1);
	endtask : t_eeprom
	// Protect window test must start right after reset release
	initial
	begin
		core_clk_i = 1'b0;
		rst_n_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 18'h0_0000;
		pwdata_i = 32'h0000_0000;
		special_mode_i = 1'b0;
		eprom_rdata_i = 8'h3C;
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		t_protect();
		t_special();
		t_eprom();
		t_eeprom();
		print_verdict();
	end
	// Watchdog far beyond the expected run length
	initial
	begin
		#80000;
		mismatches++;
		print_verdict();
	end
endmodule : npe_nvm_ctrl_tb
`default_nettype wire
